// ===== shared/ctrl_bank_cfg.svh
// Offsets, field positions, reset values and serial framing bit counts of the bank.
`ifndef CTRL_BANK_CFG_SVH
`define CTRL_BANK_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_CHANNEL_INDEX   13'h005
`define OFS_POWER_MODE      13'h008
`define OFS_ENHANCEMENT     13'h00c
`define OFS_OUTPUT_MODE     13'h014
`define OFS_SERIAL_STREAM   13'h021
`define OFS_CHANNEL_POWER   13'h022
`define OFS_OVERRIDE_COMMIT 13'h0ff
`define OFS_RATE_OVERRIDE   13'h100
`define OFS_PAD_TWO         13'h101
`define OFS_PAD_THREE       13'h102

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CHANNEL_INDEX   8'h0f
`define RST_POWER_MODE      8'h00
`define RST_ENHANCEMENT     8'h00
`define RST_OUTPUT_MODE     8'h01
`define RST_SERIAL_STREAM   8'h30
`define RST_CHANNEL_POWER   8'h00
`define RST_RATE_OVERRIDE   8'h00
`define RST_PAD             8'h00

// ----------------------------------------------------------------------
// Writable bit masks and field positions
// ----------------------------------------------------------------------
`define MSK_CHANNEL_INDEX   8'h3f
`define MSK_POWER_MODE      8'h03
`define MSK_ENHANCEMENT     8'h04
`define MSK_OUTPUT_MODE     8'h45
`define MSK_SERIAL_STREAM   8'hff
`define MSK_CHANNEL_POWER   8'h03
`define MSK_RATE_OVERRIDE   8'h77
`define MSK_PAD_TWO         8'h01
`define MSK_PAD_THREE       8'h08
`define MSK_COMMIT          8'h01
`define MSK_CLOCK_CHANNEL   8'h03
`define BIT_CHOP            2
`define BIT_PAD_PULLDOWN    0
`define BIT_CM_POWERDOWN    3
`define BIT_COMMIT          0
`define BIT_OVR_ENABLE      6
`define BIT_CH_POWERDOWN    0
`define BIT_CH_OUT_RESET    1
`define BIT_ORDER           7
`define BIT_ENCODE_LOW      3
`define BIT_FRAME_2X        2

// ----------------------------------------------------------------------
// Serial port framing
// ----------------------------------------------------------------------
`define SPI_HDR_BITS        16
`define SPI_DATA_BITS       8
`define SPI_CNT_W           5

`endif

// ===== shared/ctrl_bank_pkg.sv
// Types shared by the control register bank.
package ctrl_bank_pkg;
  typedef enum logic [1:0] {
    PWR_NORMAL  = 2'h0,
    PWR_DOWN    = 2'h1,
    PWR_STANDBY = 2'h2,
    PWR_RESET   = 2'h3
  } power_mode_t;

  typedef enum logic [1:0] {
    SP_HEADER = 2'h0,
    SP_DATA   = 2'h1,
    SP_DONE   = 2'h3
  } sp_state_t;

  typedef logic [7:0]  byte_t;
  typedef logic [12:0] addr_t;
endpackage : ctrl_bank_pkg

// ===== hw/serial_ctrl_port.sv
// Three-wire serial control port that frames reads and writes.
`timescale 1ns/100ps
`include "ctrl_bank_cfg.svh"
module serial_ctrl_port (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 sclk,
  input  wire logic                 csb_n,
  input  wire logic                 sdio_in,
  input  ctrl_bank_pkg::byte_t      rd_data,
  output logic                      sdio_out,
  output logic                      sdio_oe,
  output ctrl_bank_pkg::addr_t      addr,
  output ctrl_bank_pkg::byte_t      wr_data,
  output logic                      wr_stb
);
  import ctrl_bank_pkg::*;

  // --------------------------------------------------------------------
  // Edge detection and frame state
  // --------------------------------------------------------------------
  logic                    sclk_reg;
  sp_state_t               state_reg;
  sp_state_t               state_next;
  logic [`SPI_CNT_W-1:0]   cnt_reg;
  logic [15:0]             hdr_reg;
  byte_t                   sh_reg;
  logic                    rd_reg;
  logic                    rise;
  logic                    fall;
  logic                    hdr_last;
  logic                    dat_last;

  assign rise     = sclk & ~sclk_reg;
  assign fall     = ~sclk & sclk_reg;
  assign hdr_last = (cnt_reg == `SPI_CNT_W'(`SPI_HDR_BITS - 1));
  assign dat_last = (cnt_reg == `SPI_CNT_W'(`SPI_DATA_BITS - 1));
  assign addr     = hdr_reg[12:0];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SP_HEADER: if (rise && hdr_last) state_next = SP_DATA;
      SP_DATA:   if (rise && dat_last) state_next = SP_DONE;
      SP_DONE:   state_next = SP_DONE;
      default:   state_next = SP_HEADER;
    endcase
    if (csb_n) state_next = SP_HEADER;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_reg  <= 1'b0;
      state_reg <= SP_HEADER;
      cnt_reg   <= '0;
      hdr_reg   <= 16'h0000;
      sh_reg    <= 8'h00;
      rd_reg    <= 1'b0;
      wr_stb    <= 1'b0;
      wr_data   <= 8'h00;
      sdio_out  <= 1'b0;
      sdio_oe   <= 1'b0;
    end else begin
      sclk_reg  <= sclk;
      state_reg <= state_next;
      wr_stb    <= 1'b0;
      if (csb_n) begin
        cnt_reg <= '0;
        sdio_oe <= 1'b0;
      end else if (rise && state_reg == SP_HEADER) begin
        hdr_reg <= {hdr_reg[14:0], sdio_in};
        cnt_reg <= hdr_last ? '0 : cnt_reg + `SPI_CNT_W'(1);
        if (hdr_last) begin
          rd_reg <= hdr_reg[14];
        end
      end else if (rise && state_reg == SP_DATA) begin
        sh_reg  <= {sh_reg[6:0], sdio_in};
        cnt_reg <= cnt_reg + `SPI_CNT_W'(1);
        if (dat_last && !rd_reg) begin
          wr_data <= {sh_reg[6:0], sdio_in};
          wr_stb  <= 1'b1;
        end
      end else if (fall && state_reg == SP_DATA && rd_reg) begin
        sdio_oe  <= 1'b1;
        sdio_out <= rd_data[3'(`SPI_DATA_BITS - 1) - cnt_reg[2:0]];
      end
    end
  end
endmodule : serial_ctrl_port

// ===== hw/ctrl_register_bank.sv
// Control register bank of a dual-channel converter behind a serial port.
//
// Behaviour
// RULE1: Per-channel writes go to indexed data channels.
// RULE2: Clock channels selectable, only reduced feature subset.
// RULE3: All registers except override act immediately.
// RULE4: Override takes effect only on commit bit write.
// RULE5: Normal mode keeps both channels active.
// RULE6: Power-down gates clocks, resets datapath, disables outputs.
// RULE7: Standby gates clocks and outputs, no reset.
// RULE8: Digital reset resets datapath, spares serial port.
// RULE9: Only power-on reset resets serial port.
// RULE10: Chop bit enables first-stage chopping.
// RULE11: Host sets one-lane DDR, low encode below limit.
// RULE12: Serial stream register holds five documented fields.
// RULE13: Three-bit rate code spans 20 to 125.
// RULE14: Rate code caps capability, not actual rate.
// RULE15: Pad bit disables serial data pull-down.
// RULE16: Pad bit powers down common-mode generator.
// RULE17: Channel register powers down, resets output logic.
// RULE18: Open bits read zero, ignore writes.
`timescale 1ns/100ps
`include "ctrl_bank_cfg.svh"
module ctrl_register_bank #(
  parameter int CHANNELS = 2
) (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST,
  input  wire logic                  SCLK,
  input  wire logic                  CSB_N,
  input  wire logic                  SDIO_IN,
  output logic                       SDIO_OUT,
  output logic                       SDIO_OE,
  output logic                       SDIO_PULLDOWN_EN,
  output logic                       CM_GEN_POWERDOWN,
  output logic [CHANNELS-1:0]        CH_ACTIVE,
  output logic [CHANNELS-1:0]        CH_CLK_EN,
  output logic [CHANNELS-1:0]        CH_DATAPATH_RESET,
  output logic [CHANNELS-1:0]        CH_OUTPUT_EN,
  output logic [CHANNELS-1:0]        CH_OUTPUT_RESET,
  output logic [CHANNELS-1:0]        CH_CHOP_EN,
  output logic [CHANNELS-1:0]        CH_INVERT,
  output logic [CHANNELS-1:0]        CH_TWOS_COMP,
  output logic [1:0]                 CLKOUT_INVERT,
  output logic                       LVDS_REDUCED,
  output logic                       BIT_ORDER_LSB,
  output logic [2:0]                 LANE_MODE,
  output logic                       ENCODE_LOW,
  output logic                       FRAME_2X,
  output logic [1:0]                 WORD_SIZE,
  output logic                       OVR_ENABLE,
  output logic [1:0]                 OVR_RESOLUTION,
  output logic [2:0]                 OVR_RATE_CLASS
);
  import ctrl_bank_pkg::*;

  // --------------------------------------------------------------------
  // Serial control port
  // --------------------------------------------------------------------
  addr_t        sp_addr;
  byte_t        sp_wdata;
  logic         sp_wr;
  byte_t        rd_data;
  logic         sdio_out_w;
  logic         sdio_oe_w;

  serial_ctrl_port u_port (
    .clk      (CLK_SYS),
    .rst      (RST),
    .sclk     (SCLK),
    .csb_n    (CSB_N),
    .sdio_in  (SDIO_IN),
    .rd_data  (rd_data),
    .sdio_out (sdio_out_w),
    .sdio_oe  (sdio_oe_w),
    .addr     (sp_addr),
    .wr_data  (sp_wdata),
    .wr_stb   (sp_wr)
  ); // [RULE9]

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  logic         hit_index;
  logic         hit_power;
  logic         hit_enh;
  logic         hit_omode;
  logic         hit_stream;
  logic         hit_chpwr;
  logic         hit_commit;
  logic         hit_ovr;
  logic         hit_pad2;
  logic         hit_pad3;

  assign hit_index  = (sp_addr == `OFS_CHANNEL_INDEX);
  assign hit_power  = (sp_addr == `OFS_POWER_MODE);
  assign hit_enh    = (sp_addr == `OFS_ENHANCEMENT);
  assign hit_omode  = (sp_addr == `OFS_OUTPUT_MODE);
  assign hit_stream = (sp_addr == `OFS_SERIAL_STREAM);
  assign hit_chpwr  = (sp_addr == `OFS_CHANNEL_POWER);
  assign hit_commit = (sp_addr == `OFS_OVERRIDE_COMMIT);
  assign hit_ovr    = (sp_addr == `OFS_RATE_OVERRIDE);
  assign hit_pad2   = (sp_addr == `OFS_PAD_TWO);
  assign hit_pad3   = (sp_addr == `OFS_PAD_THREE);

  // --------------------------------------------------------------------
  // Global registers
  // --------------------------------------------------------------------
  byte_t        index_reg;
  byte_t        power_reg;
  byte_t        stream_reg;
  byte_t        ovr_stage_reg;
  byte_t        ovr_live_reg;
  byte_t        pad2_reg;
  byte_t        pad3_reg;
  logic         commit_w;
  logic         lvds_reduced_reg;
  byte_t        clk_omode_reg;
  power_mode_t  pmode;

  assign commit_w = sp_wr && hit_commit && sp_wdata[`BIT_COMMIT]; // [RULE4]
  assign pmode    = power_mode_t'(power_reg[1:0]);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      index_reg        <= `RST_CHANNEL_INDEX;
      power_reg        <= `RST_POWER_MODE;
      stream_reg       <= `RST_SERIAL_STREAM;
      ovr_stage_reg    <= `RST_RATE_OVERRIDE;
      ovr_live_reg     <= `RST_RATE_OVERRIDE;
      pad2_reg         <= `RST_PAD;
      pad3_reg         <= `RST_PAD;
      lvds_reduced_reg <= 1'b0;
      clk_omode_reg    <= 8'h00;
    end else begin
      if (sp_wr && hit_index) begin
        index_reg <= sp_wdata & `MSK_CHANNEL_INDEX; // [RULE18]
      end
      if (sp_wr && hit_power) begin
        power_reg <= sp_wdata & `MSK_POWER_MODE; // [RULE3]
      end
      if (sp_wr && hit_stream) begin
        stream_reg <= sp_wdata & `MSK_SERIAL_STREAM; // [RULE12]
      end
      if (sp_wr && hit_ovr) begin
        ovr_stage_reg <= sp_wdata & `MSK_RATE_OVERRIDE;
      end
      if (commit_w) begin
        ovr_live_reg <= ovr_stage_reg; // [RULE4]
      end
      if (sp_wr && hit_pad2) begin
        pad2_reg <= sp_wdata & `MSK_PAD_TWO;
      end
      if (sp_wr && hit_pad3) begin
        pad3_reg <= sp_wdata & `MSK_PAD_THREE;
      end
      if (sp_wr && hit_omode) begin
        lvds_reduced_reg <= sp_wdata[6];
        // Clock outputs only take the invert feature.
        clk_omode_reg <= (clk_omode_reg & ~{6'h00, index_reg[5:4]})
                       | ({8{sp_wdata[2]}}
                          & {6'h00, index_reg[5:4]}); // [RULE2]
      end
    end
  end

  // --------------------------------------------------------------------
  // Per-channel registers
  // --------------------------------------------------------------------
  byte_t        enh_reg   [CHANNELS];
  byte_t        omode_reg [CHANNELS];
  byte_t        chpwr_reg [CHANNELS];
  logic [CHANNELS-1:0] sel;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      assign sel[g] = index_reg[g]; // [RULE1]
      always_ff @(posedge CLK_SYS) begin
        if (RST) begin
          enh_reg[g]   <= `RST_ENHANCEMENT;
          omode_reg[g] <= `RST_OUTPUT_MODE;
          chpwr_reg[g] <= `RST_CHANNEL_POWER;
        end else begin
          if (sp_wr && hit_enh && sel[g]) begin
            enh_reg[g] <= sp_wdata & `MSK_ENHANCEMENT; // [RULE1]
          end
          if (sp_wr && hit_omode && sel[g]) begin
            omode_reg[g] <= sp_wdata & `MSK_OUTPUT_MODE;
          end
          if (sp_wr && hit_chpwr && sel[g]) begin
            chpwr_reg[g] <= sp_wdata & `MSK_CHANNEL_POWER; // [RULE17]
          end
        end
      end

      // Power mode steering of each channel.
      always_ff @(posedge CLK_SYS) begin
        if (RST) begin
          CH_ACTIVE[g]         <= 1'b1;
          CH_CLK_EN[g]         <= 1'b1;
          CH_DATAPATH_RESET[g] <= 1'b0;
          CH_OUTPUT_EN[g]      <= 1'b1;
          CH_OUTPUT_RESET[g]   <= 1'b0;
          CH_CHOP_EN[g]        <= 1'b0;
          CH_INVERT[g]         <= 1'b0;
          CH_TWOS_COMP[g]      <= 1'b1;
        end else begin
          CH_ACTIVE[g]         <= (pmode == PWR_NORMAL)
                                  && !chpwr_reg[g][`BIT_CH_POWERDOWN];
                                  // [RULE5] [RULE17]
          CH_CLK_EN[g]         <= (pmode == PWR_NORMAL)
                                  && !chpwr_reg[g][`BIT_CH_POWERDOWN];
                                  // [RULE6] [RULE7]
          CH_DATAPATH_RESET[g] <= (pmode == PWR_DOWN)
                                  || (pmode == PWR_RESET); // [RULE6] [RULE8]
          CH_OUTPUT_EN[g]      <= (pmode == PWR_NORMAL)
                                  || (pmode == PWR_RESET); // [RULE6] [RULE7]
          CH_OUTPUT_RESET[g]   <= (pmode == PWR_RESET)
                                  || chpwr_reg[g][`BIT_CH_OUT_RESET];
                                  // [RULE8] [RULE17]
          CH_CHOP_EN[g]        <= enh_reg[g][`BIT_CHOP]; // [RULE10]
          CH_INVERT[g]         <= omode_reg[g][2];
          CH_TWOS_COMP[g]      <= omode_reg[g][0];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Read-back of the first selected channel
  // --------------------------------------------------------------------
  logic         rd_ch;
  byte_t        ch_enh;
  byte_t        ch_omode;
  byte_t        ch_pwr;

  assign rd_ch    = ~index_reg[0];
  assign ch_enh   = enh_reg[rd_ch];
  assign ch_omode = {1'b0, lvds_reduced_reg, omode_reg[rd_ch][5:0]};
  assign ch_pwr   = chpwr_reg[rd_ch];

  // Open bits are masked on write, so they read back zero.
  assign rd_data = hit_index  ? index_reg
                 : hit_power  ? power_reg
                 : hit_enh    ? ch_enh
                 : hit_omode  ? ch_omode
                 : hit_stream ? stream_reg
                 : hit_chpwr  ? ch_pwr
                 : hit_ovr    ? ovr_stage_reg
                 : hit_pad2   ? pad2_reg
                 : hit_pad3   ? pad3_reg
                 : 8'h00; // [RULE18]

  // --------------------------------------------------------------------
  // Global outputs
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      SDIO_OUT         <= 1'b0;
      SDIO_OE          <= 1'b0;
      SDIO_PULLDOWN_EN <= 1'b1;
      CM_GEN_POWERDOWN <= 1'b0;
      CLKOUT_INVERT    <= 2'h0;
      LVDS_REDUCED     <= 1'b0;
      BIT_ORDER_LSB    <= 1'b0;
      LANE_MODE        <= 3'h3;
      ENCODE_LOW       <= 1'b0;
      FRAME_2X         <= 1'b0;
      WORD_SIZE        <= 2'h0;
      OVR_ENABLE       <= 1'b0;
      OVR_RESOLUTION   <= 2'h0;
      OVR_RATE_CLASS   <= 3'h0;
    end else begin
      SDIO_OUT         <= sdio_out_w;
      SDIO_OE          <= sdio_oe_w;
      SDIO_PULLDOWN_EN <= !pad2_reg[`BIT_PAD_PULLDOWN]; // [RULE15]
      CM_GEN_POWERDOWN <= pad3_reg[`BIT_CM_POWERDOWN]; // [RULE16]
      CLKOUT_INVERT    <= clk_omode_reg[1:0]; // [RULE2]
      LVDS_REDUCED     <= lvds_reduced_reg;
      BIT_ORDER_LSB    <= stream_reg[`BIT_ORDER]; // [RULE12]
      LANE_MODE        <= stream_reg[6:4]; // [RULE12] [RULE11]
      ENCODE_LOW       <= stream_reg[`BIT_ENCODE_LOW]; // [RULE12]
      FRAME_2X         <= stream_reg[`BIT_FRAME_2X];
      WORD_SIZE        <= stream_reg[1:0];
      OVR_ENABLE       <= ovr_live_reg[`BIT_OVR_ENABLE];
      OVR_RESOLUTION   <= ovr_live_reg[5:4];
      // Capability cap only; the sample clock is untouched.
      OVR_RATE_CLASS   <= ovr_live_reg[2:0]; // [RULE13] [RULE14]
    end
  end
endmodule : ctrl_register_bank

// ===== test/ctrl_bank_monitor.sv
// Concurrent checks on the outputs of the control register bank.
`timescale 1ns/100ps
module ctrl_bank_monitor #(
  parameter int CHANNELS = 2
) (
  input wire logic                CLK_SYS,
  input wire logic                RST,
  input wire logic                CSB_N,
  input wire logic                SDIO_OE,
  input wire logic                SDIO_PULLDOWN_EN,
  input wire logic                CM_GEN_POWERDOWN,
  input wire logic [CHANNELS-1:0] CH_ACTIVE,
  input wire logic [CHANNELS-1:0] CH_CLK_EN,
  input wire logic [CHANNELS-1:0] CH_DATAPATH_RESET,
  input wire logic [CHANNELS-1:0] CH_OUTPUT_EN,
  input wire logic [CHANNELS-1:0] CH_OUTPUT_RESET,
  input wire logic [2:0]          LANE_MODE,
  input wire logic                OVR_ENABLE,
  input wire logic [2:0]          OVR_RATE_CLASS
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_idle;
    CSB_N [*4];
  endsequence
  a_normal_on: assert property (CH_ACTIVE[0] |->
    CH_CLK_EN[0] && CH_OUTPUT_EN[0] && !CH_DATAPATH_RESET[0])
    else $error("active channel not fully running");
  a_down_gated: assert property (CH_DATAPATH_RESET[0] &&
    !CH_OUTPUT_EN[0] |-> CH_CLK_EN == 0 && CH_DATAPATH_RESET == '1)
    else $error("power-down mode left clocks running");
  a_standby_gated: assert property (!CH_DATAPATH_RESET[0] &&
    !CH_OUTPUT_EN[0] |-> CH_CLK_EN == 0)
    else $error("standby mode left clocks running");
  a_dig_reset: assert property (CH_DATAPATH_RESET[0] &&
    CH_OUTPUT_EN[0] |-> CH_OUTPUT_RESET == '1 && CH_CLK_EN == 0)
    else $error("digital reset mode not holding outputs");
  a_chan_off: assert property (CH_OUTPUT_EN[0] &&
    !CH_DATAPATH_RESET[0] && !CH_ACTIVE[0] |-> !CH_CLK_EN[0])
    else $error("powered-down channel keeps its clock");
  a_reset_out: assert property ($fell(RST) |-> LANE_MODE == 3'h3 &&
    SDIO_PULLDOWN_EN && !OVR_ENABLE && OVR_RATE_CLASS == 3'h0)
    else $error("outputs wrong after reset");
  a_ovr_frame: assert property (
    !$stable({OVR_ENABLE, OVR_RATE_CLASS}) |-> !CSB_N)
    else $error("override moved outside a frame");
  a_idle_hold: assert property (s_idle |-> $stable({LANE_MODE,
    SDIO_PULLDOWN_EN, CM_GEN_POWERDOWN, CH_CLK_EN, CH_OUTPUT_EN}))
    else $error("settings moved with the port idle");
  a_oe_release: assert property ($rose(CSB_N) |-> ##[1:2] !SDIO_OE)
    else $error("data line still driven after deselect");
endmodule : ctrl_bank_monitor

bind ctrl_register_bank ctrl_bank_monitor #(.CHANNELS(CHANNELS)) mon (
  .CLK_SYS(CLK_SYS), .RST(RST), .CSB_N(CSB_N), .SDIO_OE(SDIO_OE),
  .SDIO_PULLDOWN_EN(SDIO_PULLDOWN_EN), .CM_GEN_POWERDOWN(CM_GEN_POWERDOWN),
  .CH_ACTIVE(CH_ACTIVE), .CH_CLK_EN(CH_CLK_EN),
  .CH_DATAPATH_RESET(CH_DATAPATH_RESET), .CH_OUTPUT_EN(CH_OUTPUT_EN),
  .CH_OUTPUT_RESET(CH_OUTPUT_RESET), .LANE_MODE(LANE_MODE),
  .OVR_ENABLE(OVR_ENABLE), .OVR_RATE_CLASS(OVR_RATE_CLASS));

// ===== test/serial_host_model.sv
// Host side of the three-wire serial control port.
`timescale 1ns/100ps
module serial_host_model (
  input wire logic clk,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic pulldown_en,
  output logic     sclk,
  output logic     csb_n,
  output logic     sdio_line
);
  logic host_oe;
  logic host_d;
  logic last_v;
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    host_oe = 1'b0;
    host_d = 1'b0;
    last_v = 1'b0;
  end
  // A released line falls to the pull-down or shows the inverse value.
  always_comb begin
    if (sdio_oe) sdio_line = sdio_out;
    else if (host_oe) sdio_line = host_d;
    else sdio_line = pulldown_en ? 1'b0 : ~last_v;
  end
  always @(posedge clk) last_v <= sdio_line;
  // One frame: header then one data byte, MSB first, slow serial clock.
  task automatic xfer(input logic rd, input logic [12:0] a,
                      input logic [7:0] wd, output logic [7:0] q);
    logic [23:0] f;
    f = {rd, 2'b00, a, wd};
    q = 8'h00;
    @(posedge clk) #1 csb_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      #1 sclk = 1'b0;
      host_oe = !(rd && i < 8);
      host_d = f[i];
      repeat (4) @(posedge clk);
      #1 if (i < 8) q[i] = sdio_line;
      sclk = 1'b1;
    end
    repeat (8) @(posedge clk);
    #1 sclk = 1'b0;
    csb_n = 1'b1;
    host_oe = 1'b0;
    repeat (6) @(posedge clk);
  endtask : xfer
endmodule : serial_host_model

// ===== test/test_ctrl_register_bank.sv
// Self-checking bench for the control register bank.
`timescale 1ns/100ps
module test_ctrl_register_bank;
  import ctrl_bank_pkg::*;
  logic CLK_SYS, RST, SCLK, CSB_N, SDIO_IN, SDIO_OUT, SDIO_OE;
  logic SDIO_PULLDOWN_EN, CM_GEN_POWERDOWN, LVDS_REDUCED, BIT_ORDER_LSB;
  logic ENCODE_LOW, FRAME_2X, OVR_ENABLE;
  logic [1:0] CH_ACTIVE, CH_CLK_EN, CH_DATAPATH_RESET, CH_OUTPUT_EN;
  logic [1:0] CH_OUTPUT_RESET, CH_CHOP_EN, CH_INVERT, CH_TWOS_COMP;
  logic [1:0] CLKOUT_INVERT, WORD_SIZE, OVR_RESOLUTION;
  logic [2:0] LANE_MODE, OVR_RATE_CLASS;
  int err_total = 0;
  int total_checks = 0;
  addr_t ra [8] = '{13'h005, 13'h008, 13'h00c, 13'h014, 13'h021, 13'h022,
                    13'h100, 13'h0ff};
  byte_t rv [8] = '{8'h0f, 8'h00, 8'h00, 8'h01, 8'h30, 8'h00, 8'h00, 8'h00};
  byte_t me [4] = '{8'hcc, 8'h30, 8'h00, 8'h3f};

  ctrl_register_bank #(.CHANNELS(2)) uut (
    .CLK_SYS(CLK_SYS), .RST(RST), .SCLK(SCLK), .CSB_N(CSB_N),
    .SDIO_IN(SDIO_IN), .SDIO_OUT(SDIO_OUT), .SDIO_OE(SDIO_OE),
    .SDIO_PULLDOWN_EN(SDIO_PULLDOWN_EN), .CM_GEN_POWERDOWN(CM_GEN_POWERDOWN),
    .CH_ACTIVE(CH_ACTIVE), .CH_CLK_EN(CH_CLK_EN),
    .CH_DATAPATH_RESET(CH_DATAPATH_RESET), .CH_OUTPUT_EN(CH_OUTPUT_EN),
    .CH_OUTPUT_RESET(CH_OUTPUT_RESET), .CH_CHOP_EN(CH_CHOP_EN),
    .CH_INVERT(CH_INVERT), .CH_TWOS_COMP(CH_TWOS_COMP),
    .CLKOUT_INVERT(CLKOUT_INVERT), .LVDS_REDUCED(LVDS_REDUCED),
    .BIT_ORDER_LSB(BIT_ORDER_LSB), .LANE_MODE(LANE_MODE),
    .ENCODE_LOW(ENCODE_LOW), .FRAME_2X(FRAME_2X), .WORD_SIZE(WORD_SIZE),
    .OVR_ENABLE(OVR_ENABLE), .OVR_RESOLUTION(OVR_RESOLUTION),
    .OVR_RATE_CLASS(OVR_RATE_CLASS));

  serial_host_model host (
    .clk(CLK_SYS), .sdio_out(SDIO_OUT), .sdio_oe(SDIO_OE),
    .pulldown_en(SDIO_PULLDOWN_EN), .sclk(SCLK), .csb_n(CSB_N),
    .sdio_line(SDIO_IN));

  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end

  task automatic chk(input byte_t got, input byte_t exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input addr_t a, input byte_t d);
    byte_t q;
    host.xfer(1'b0, a, d, q);
  endtask : wr

  task automatic rd(input addr_t a, input byte_t e);
    byte_t q;
    host.xfer(1'b1, a, 8'h00, q);
    chk(q, e);
  endtask : rd

  task automatic summarize;
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (50000) @(posedge CLK_SYS);
    err_total++;
    summarize();
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    RST = 1'b1;
    repeat (10) @(posedge CLK_SYS);
    #1 RST = 1'b0;
    repeat (2) @(posedge CLK_SYS);
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], rv[i]);
    end
    wr(13'h00c, 8'hff);
    rd(13'h00c, 8'h04);
    chk({6'h00, CH_CHOP_EN}, 8'h03);
    wr(13'h101, 8'hff);
    rd(13'h101, 8'h01);
    chk({7'h00, SDIO_PULLDOWN_EN}, 8'h00);
    wr(13'h102, 8'hff);
    rd(13'h102, 8'h08);
    chk({7'h00, CM_GEN_POWERDOWN}, 8'h01);
    wr(13'h1ff, 8'h5a);
    rd(13'h1ff, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(13'h008, byte_t'(m));
      chk({CH_CLK_EN, CH_DATAPATH_RESET, CH_OUTPUT_EN, CH_OUTPUT_RESET},
          me[m]);
      rd(13'h021, 8'h30);
    end
    wr(13'h008, 8'h00);
    wr(13'h005, 8'h01);
    wr(13'h022, 8'h01);
    chk({6'h00, CH_ACTIVE}, 8'h02);
    wr(13'h022, 8'h02);
    chk({4'h0, CH_ACTIVE, CH_OUTPUT_RESET}, 8'h0d);
    wr(13'h005, 8'h02);
    wr(13'h00c, 8'h00);
    chk({6'h00, CH_CHOP_EN}, 8'h01);
    wr(13'h021, 8'hcd);
    chk({BIT_ORDER_LSB, LANE_MODE, ENCODE_LOW, FRAME_2X, WORD_SIZE},
        8'hcd);
    wr(13'h005, 8'h30);
    wr(13'h014, 8'h44);
    chk({LVDS_REDUCED, 1'b0, CH_TWOS_COMP, CLKOUT_INVERT, CH_INVERT},
        8'hbc);
    wr(13'h00c, 8'h04);
    chk({6'h00, CH_CHOP_EN}, 8'h01);
    wr(13'h100, 8'h46);
    chk({2'b00, OVR_ENABLE, OVR_RESOLUTION, OVR_RATE_CLASS}, 8'h00);
    rd(13'h100, 8'h46);
    wr(13'h0ff, 8'h01);
    chk({2'b00, OVR_ENABLE, OVR_RESOLUTION, OVR_RATE_CLASS}, 8'h26);
    wr(13'h100, 8'h50);
    chk({2'b00, OVR_ENABLE, OVR_RESOLUTION, OVR_RATE_CLASS}, 8'h26);
    wr(13'h0ff, 8'h01);
    chk({2'b00, OVR_ENABLE, OVR_RESOLUTION, OVR_RATE_CLASS}, 8'h28);
    #1 RST = 1'b1;
    repeat (10) @(posedge CLK_SYS);
    #1 RST = 1'b0;
    repeat (2) @(posedge CLK_SYS);
    chk({BIT_ORDER_LSB, LANE_MODE, ENCODE_LOW, FRAME_2X, WORD_SIZE},
        8'h30);
    rd(13'h005, 8'h0f);
    summarize();
  end
endmodule : test_ctrl_register_bank
